/* rtl/pcb_bank.sv */
// Register bank with chroma test, user interrupt and tallies
// Notes on behaviour
// - Rect clear writes depth constant bits 15:0 into cleared depth locations.
// - Depth bias enabled by mode bit 16 takes bias from depth bits 15:0.
// - Depth constant gives alpha 31:24 and depth 15:0 for linear writes.
// - Chroma on, range off: discard pixel whose RGB equals the key.
// - Range compare only when mode bit 1 and range bit 28 set.
// - Comparisons ignore alpha, use only red, green and blue.
// - Chroma test sits after texture lookup, before lighting, fog, blending.
// - Key register holds blue 7:0, green 15:8, red 23:16; top reserved.
// - Each component range spans key lower to range upper, inclusive.
// - Bits 24..26 per component: 0 prohibits inside, 1 prohibits outside.
// - Bit 27: 0 blocks when all prohibit, 1 when any prohibits.
// - Software irq write with bit 0 raises user interrupt, control bit 11.
// - Bit 1 stalls command processing until user interrupt cleared.
// - Tag bits 9:2 copied to control bits 19:12, latest wins.
// - With control bit 5 clear, software irq writes are dropped.
// - Write mask register supplies 32-bit stipple mask.
// - Local colour 23:0 and 31:24 feed colour and alpha combine.
// - Other colour feeds combine units when path bits select it.
// - Rect clear uses other colour 23:0 as clear RGB.
// - Triangle tally counts walked, non-culled triangles; flush bit 1 clears.
// - Pixel tally counts every walked pixel; flush bit 0 clears.
`timescale 1ns/10ps
`default_nettype none
module pcb_bank #(
  parameter int TALLY_WIDTH = pcb_pkg::TALLY_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pixel pipeline chroma test
  input wire logic pix_valid_i,
  input wire pcb_pkg::pcb_rgb_s pix_rgb_i,
  output logic pix_block_o,
  // Pipeline events
  input wire logic tri_walked_i,
  input wire logic tri_culled_i,
  input wire logic pix_walked_i,
  // Constants to pipeline
  output pcb_pkg::pcb_const_s const_o,
  output logic [23:0] combine_other_rgb_o,
  output logic [7:0] combine_other_alpha_o,
  output logic other_rgb_sel_o,
  output logic other_alpha_sel_o,
  // Engine control
  output logic engine_stall_o,
  output logic user_irq_o
);
  import pcb_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [31:0] haze_r, haze_nxt, za_r, za_nxt, key_r, key_nxt;
  logic [31:0] range_r, range_nxt, mask_r, mask_nxt, loc_r, loc_nxt;
  logic [31:0] oth_r, oth_nxt, fbmode_r, fbmode_nxt, irqctl_r, irqctl_nxt;
  logic [31:0] cpath_r, cpath_nxt, rdata_nxt;
  logic stall_r, stall_nxt, ack_r, ack_nxt, block_r, block_nxt;
  logic [TALLY_WIDTH-1:0] tri_r, tri_nxt, pix_r, pix_nxt;
  logic req, wr;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel, input logic [31:0] msk);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res & msk;
  endfunction : merge

  // Range test of one component: prohibited or not
  function automatic logic comp_bad(input logic [7:0] v, input logic [7:0] lo,
                                    input logic [7:0] hi, input logic excl);
    logic in_rng;
    in_rng = (v >= lo) && (v <= hi);
    return excl ? !in_rng : in_rng;
  endfunction : comp_bad

  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr = req && wb_we_i;

  ////////////////////////////////////////////////////////////////////////
  // Register file
  always_comb begin
    haze_nxt = haze_r;
    za_nxt = za_r;
    key_nxt = key_r;
    range_nxt = range_r;
    mask_nxt = mask_r;
    loc_nxt = loc_r;
    oth_nxt = oth_r;
    fbmode_nxt = fbmode_r;
    irqctl_nxt = irqctl_r;
    cpath_nxt = cpath_r;
    stall_nxt = stall_r;
    ack_nxt = req;
    rdata_nxt = 32'h0000_0000;
    if (wr) begin
      case (wb_adr_i)
        OFF_HAZE: haze_nxt = merge(haze_r, wb_dat_i, wb_sel_i, KEY_MASK);
        OFF_ZA: za_nxt = merge(za_r, wb_dat_i, wb_sel_i, ZA_MASK);
        OFF_KEY: key_nxt = merge(key_r, wb_dat_i, wb_sel_i, KEY_MASK);
        OFF_RANGE: range_nxt = merge(range_r, wb_dat_i, wb_sel_i, RANGE_MASK);
        OFF_MASK: mask_nxt = merge(mask_r, wb_dat_i, wb_sel_i, 32'hffff_ffff);
        OFF_LOCAL: loc_nxt = merge(loc_r, wb_dat_i, wb_sel_i, 32'hffff_ffff);
        OFF_OTHER: oth_nxt = merge(oth_r, wb_dat_i, wb_sel_i, 32'hffff_ffff);
        OFF_FBMODE: fbmode_nxt = merge(fbmode_r, wb_dat_i, wb_sel_i, 32'hffff_ffff);
        OFF_CPATH: cpath_nxt = merge(cpath_r, wb_dat_i, wb_sel_i, 32'hffff_ffff);
        OFF_IRQCTL: begin
          // Writing 0 to bit 11 clears the user interrupt
          irqctl_nxt = merge(irqctl_r, wb_dat_i, wb_sel_i, IC_MASK);
        end
        OFF_SWIRQ: begin
          // Whole word command; dropped unless enabled
          if (irqctl_r[IC_ENABLE]) begin
            irqctl_nxt[IC_TAG_LO +: 8] = wb_dat_i[SW_TAG_LO +: 8];
            if (wb_dat_i[SW_GEN]) begin
              irqctl_nxt[IC_USER] = 1'b1;
            end
            if (wb_dat_i[SW_STALL]) begin
              stall_nxt = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end
    // Stall lasts only while the user interrupt stands
    if (!irqctl_nxt[IC_USER]) begin
      stall_nxt = 1'b0;
    end
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        OFF_HAZE: rdata_nxt = haze_r;
        OFF_ZA: rdata_nxt = za_r;
        OFF_KEY: rdata_nxt = key_r;
        OFF_RANGE: rdata_nxt = range_r;
        OFF_MASK: rdata_nxt = mask_r;
        OFF_LOCAL: rdata_nxt = loc_r;
        OFF_OTHER: rdata_nxt = oth_r;
        OFF_FBMODE: rdata_nxt = fbmode_r;
        OFF_CPATH: rdata_nxt = cpath_r;
        OFF_IRQCTL: rdata_nxt = irqctl_r;
        OFF_TRI: rdata_nxt = 32'(tri_r);
        OFF_PIX: rdata_nxt = 32'(pix_r);
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      haze_r <= RESET_WORD;
      za_r <= RESET_WORD;
      key_r <= RESET_WORD;
      range_r <= RESET_WORD;
      mask_r <= RESET_WORD;
      loc_r <= RESET_WORD;
      oth_r <= RESET_WORD;
      fbmode_r <= RESET_WORD;
      irqctl_r <= RESET_WORD;
      cpath_r <= RESET_WORD;
      stall_r <= 1'b0;
      ack_r <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      haze_r <= haze_nxt;
      za_r <= za_nxt;
      key_r <= key_nxt;
      range_r <= range_nxt;
      mask_r <= mask_nxt;
      loc_r <= loc_nxt;
      oth_r <= oth_nxt;
      fbmode_r <= fbmode_nxt;
      irqctl_r <= irqctl_nxt;
      cpath_r <= cpath_nxt;
      stall_r <= stall_nxt;
      ack_r <= ack_nxt;
      wb_dat_o <= rdata_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign engine_stall_o = stall_r;
  assign user_irq_o = irqctl_r[IC_USER];

  ////////////////////////////////////////////////////////////////////////
  // Statistics tallies; flush clear beats a same-cycle event
  logic flush_wr;
  assign flush_wr = wr && (wb_adr_i == OFF_FLUSH);

  always_comb begin
    tri_nxt = tri_r;
    pix_nxt = pix_r;
    if (tri_walked_i && !tri_culled_i) begin
      tri_nxt = tri_r + 1'b1;
    end
    if (pix_walked_i) begin
      pix_nxt = pix_r + 1'b1;
    end
    if (flush_wr && wb_dat_i[FL_TRI]) begin
      tri_nxt = '0;
    end
    if (flush_wr && wb_dat_i[FL_PIX]) begin
      pix_nxt = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tri_r <= '0;
      pix_r <= '0;
    end else begin
      tri_r <= tri_nxt;
      pix_r <= pix_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Chroma test on the post-texture colour, one cycle of latency
  logic [2:0] bad;
  logic exact_hit, range_hit;
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      bad[c] = comp_bad(pix_rgb_i[c*8 +: 8], key_r[c*8 +: 8], range_r[c*8 +: 8],
                        range_r[RG_MODE_B + c]);
    end
    exact_hit = (pix_rgb_i == key_r[23:0]);
    range_hit = range_r[RG_BLOCK] ? |bad : &bad;
    block_nxt = 1'b0;
    if (pix_valid_i && fbmode_r[FB_CHROMA_EN]) begin
      block_nxt = range_r[RG_ENABLE] ? range_hit : exact_hit;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      block_r <= 1'b0;
    end else begin
      block_r <= block_nxt;
    end
  end
  assign pix_block_o = block_r;

  ////////////////////////////////////////////////////////////////////////
  // Constant operands
  always_comb begin
    const_o.clear_depth = za_r[15:0];
    const_o.bias_depth = fbmode_r[FB_DEPTH_BIAS] ? za_r[15:0] : 16'h0000;
    const_o.lfb_alpha = za_r[31:24];
    const_o.lfb_depth = za_r[15:0];
    const_o.write_mask = mask_r;
    const_o.local_rgb = loc_r[23:0];
    const_o.local_alpha = loc_r[31:24];
    const_o.other_rgb = oth_r[23:0];
    const_o.other_alpha = oth_r[31:24];
    const_o.clear_rgb = oth_r[23:0];
    const_o.haze_rgb = haze_r[23:0];
  end

  // Path select code 2 picks the constant as other operand
  assign other_rgb_sel_o = (cpath_r[1:0] == 2'h2);
  assign other_alpha_sel_o = (cpath_r[3:2] == 2'h2);
  assign combine_other_rgb_o = other_rgb_sel_o ? oth_r[23:0] : 24'h00_0000;
  assign combine_other_alpha_o = other_alpha_sel_o ? oth_r[31:24] : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  AST_KEY_BLOCK: assert property (@(posedge clk_i) disable iff (rst_i)
    pix_valid_i && fbmode_r[FB_CHROMA_EN] && !range_r[RG_ENABLE]
    && pix_rgb_i == key_r[23:0]
    |=> pix_block_o)
    else $error("exact key match not blocked");

  AST_EXACT_PASS: assert property (@(posedge clk_i) disable iff (rst_i)
    pix_valid_i && fbmode_r[FB_CHROMA_EN] && !range_r[RG_ENABLE]
    && pix_rgb_i != key_r[23:0]
    |=> !pix_block_o)
    else $error("pixel off the key blocked");

  AST_DISABLED_PASS: assert property (@(posedge clk_i) disable iff (rst_i)
    !fbmode_r[FB_CHROMA_EN] |=> !pix_block_o)
    else $error("pixel blocked with chroma off");

  AST_IDLE_PASS: assert property (@(posedge clk_i) disable iff (rst_i)
    !pix_valid_i |=> !pix_block_o)
    else $error("block without a pixel");

  // Spelled out per component so it does not lean on the shared helper
  AST_RANGE_ALL_IN: assert property (@(posedge clk_i) disable iff (rst_i)
    pix_valid_i && fbmode_r[FB_CHROMA_EN] && range_r[RG_ENABLE] && !range_r[RG_BLOCK]
    && range_r[RG_MODE_B +: 3] == 3'b000
    && pix_rgb_i.r >= key_r[23:16] && pix_rgb_i.r <= range_r[23:16]
    && pix_rgb_i.g >= key_r[15:8] && pix_rgb_i.g <= range_r[15:8]
    && pix_rgb_i.b >= key_r[7:0] && pix_rgb_i.b <= range_r[7:0]
    |=> pix_block_o)
    else $error("pixel inside every range not blocked");

  AST_EXCL_UNION: assert property (@(posedge clk_i) disable iff (rst_i)
    pix_valid_i && fbmode_r[FB_CHROMA_EN] && range_r[RG_ENABLE] && range_r[RG_BLOCK]
    && range_r[RG_MODE_B + 2] && pix_rgb_i.r > range_r[23:16]
    |=> pix_block_o)
    else $error("union missed red outside exclusive range");

  AST_EXCL_INSIDE: assert property (@(posedge clk_i) disable iff (rst_i)
    pix_valid_i && fbmode_r[FB_CHROMA_EN] && range_r[RG_ENABLE] && !range_r[RG_BLOCK]
    && range_r[RG_MODE_B + 2] && pix_rgb_i.r >= key_r[23:16]
    && pix_rgb_i.r <= range_r[23:16]
    |=> !pix_block_o)
    else $error("intersection blocked with red allowed");

  AST_TAG_COPY: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_adr_i == OFF_SWIRQ && irqctl_r[IC_ENABLE]
    |=> irqctl_r[IC_TAG_LO +: 8] == $past(wb_dat_i[SW_TAG_LO +: 8]))
    else $error("tag not copied");

  AST_IRQ_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_adr_i == OFF_SWIRQ && irqctl_r[IC_ENABLE] && wb_dat_i[SW_GEN] |=> user_irq_o)
    else $error("user interrupt not raised");

  AST_DROPPED: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_adr_i == OFF_SWIRQ && !irqctl_r[IC_ENABLE] && !engine_stall_o
    |=> !engine_stall_o && $stable(irqctl_r))
    else $error("disabled command had effect");

  AST_STALL_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_adr_i == OFF_SWIRQ && irqctl_r[IC_ENABLE] && wb_dat_i[SW_GEN]
    && wb_dat_i[SW_STALL] |=> engine_stall_o)
    else $error("stall request not taken");

  AST_NO_STALL: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_adr_i == OFF_SWIRQ && irqctl_r[IC_ENABLE] && !wb_dat_i[SW_STALL]
    && !engine_stall_o |=> !engine_stall_o)
    else $error("stall without request");

  AST_STALL_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    engine_stall_o |-> user_irq_o)
    else $error("stall without pending user interrupt");

  AST_TRI_COUNT: assert property (@(posedge clk_i) disable iff (rst_i)
    tri_walked_i && tri_culled_i && !flush_wr |=> $stable(tri_r))
    else $error("culled triangle counted");

  AST_TRI_INC: assert property (@(posedge clk_i) disable iff (rst_i)
    tri_walked_i && !tri_culled_i && !flush_wr |=> tri_r == $past(tri_r) + 1'b1)
    else $error("triangle tally not incremented");

  AST_TRI_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
    flush_wr && wb_dat_i[FL_TRI] |=> tri_r == '0)
    else $error("triangle tally not cleared");

  AST_PIX_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
    flush_wr && wb_dat_i[FL_PIX] |=> pix_r == '0)
    else $error("pixel tally not cleared");

  AST_PIX_INC: assert property (@(posedge clk_i) disable iff (rst_i)
    pix_walked_i && !flush_wr |=> pix_r == $past(pix_r) + 1'b1)
    else $error("pixel tally not incremented");

  AST_BIAS_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    !fbmode_r[FB_DEPTH_BIAS] |-> const_o.bias_depth == 16'h0000)
    else $error("bias depth given while biasing off");
endmodule : pcb_bank
`default_nettype wire

/* rtl/pcb_pkg.sv */
// Package for the pixel constants and chroma test register bank
package pcb_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_HAZE = 8'h00;
  localparam logic [7:0] OFF_ZA = 8'h04;
  localparam logic [7:0] OFF_KEY = 8'h08;
  localparam logic [7:0] OFF_RANGE = 8'h0c;
  localparam logic [7:0] OFF_SWIRQ = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  localparam logic [7:0] OFF_LOCAL = 8'h18;
  localparam logic [7:0] OFF_OTHER = 8'h1c;
  localparam logic [7:0] OFF_TRI = 8'h20;
  localparam logic [7:0] OFF_PIX = 8'h24;
  localparam logic [7:0] OFF_FBMODE = 8'h28;
  localparam logic [7:0] OFF_IRQCTL = 8'h2c;
  localparam logic [7:0] OFF_FLUSH = 8'h30;
  localparam logic [7:0] OFF_CPATH = 8'h34;
  // Field positions
  localparam int FB_CHROMA_EN = 1;
  localparam int FB_DEPTH_BIAS = 16;
  localparam int RG_MODE_B = 24;
  localparam int RG_BLOCK = 27;
  localparam int RG_ENABLE = 28;
  localparam int SW_GEN = 0;
  localparam int SW_STALL = 1;
  localparam int SW_TAG_LO = 2;
  localparam int IC_ENABLE = 5;
  localparam int IC_USER = 11;
  localparam int IC_TAG_LO = 12;
  localparam int FL_PIX = 0;
  localparam int FL_TRI = 1;
  localparam int TALLY_W = 24;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [31:0] KEY_MASK = 32'h00ff_ffff;
  localparam logic [31:0] RANGE_MASK = 32'h1fff_ffff;
  localparam logic [31:0] ZA_MASK = 32'hff00_ffff;
  localparam logic [31:0] IC_MASK = 32'h000f_f820;

  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } pcb_rgb_s;

  typedef struct packed {
    logic [15:0] clear_depth;
    logic [15:0] bias_depth;
    logic [7:0] lfb_alpha;
    logic [15:0] lfb_depth;
    logic [31:0] write_mask;
    logic [23:0] local_rgb;
    logic [7:0] local_alpha;
    logic [23:0] other_rgb;
    logic [7:0] other_alpha;
    logic [23:0] clear_rgb;
    logic [23:0] haze_rgb;
  } pcb_const_s;
endpackage : pcb_pkg

/* tb/tb_top.sv */
// Self-checking bench for the pixel constants and chroma test bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import pcb_pkg::*;
  // Short tallies so the wrap is reachable in a short run
  localparam int TW = 4;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} pcb_tb_reg_s;
  typedef struct packed {logic [31:0] rng; logic [23:0] px; logic b;} pcb_tb_chr_s;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic pv = 1'b0;
  pcb_rgb_s prgb = 24'h0;
  logic tw = 1'b0;
  logic tc = 1'b0;
  logic pw = 1'b0;
  logic [31:0] rdat;
  logic ack, blk, rsel, asel, stall, irq;
  pcb_const_s cst;
  logic [23:0] corgb;
  logic [7:0] coa;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  pcb_tb_reg_s regs [10] = '{'{8'h00, 32'hffffffff, 32'h00ffffff},
    '{8'h04, 32'habcd1234, 32'hab001234}, '{8'h08, 32'hffffffff, 32'h00ffffff},
    '{8'h0c, 32'hffffffff, 32'h1fffffff}, '{8'h14, 32'ha5a55a5a, 32'ha5a55a5a},
    '{8'h18, 32'h12345678, 32'h12345678}, '{8'h1c, 32'h89abcdef, 32'h89abcdef},
    '{8'h10, 32'h00000000, 32'h00000000}, '{8'h3c, 32'hffffffff, 32'h00000000},
    '{8'h20, 32'hffffffff, 32'h00000000}};
  pcb_tb_chr_s chr [10] = '{'{32'h0, 24'h101010, 1'b1}, '{32'h0, 24'h101011, 1'b0},
    '{32'h10202020, 24'h201010, 1'b1}, '{32'h10202020, 24'h211515, 1'b0},
    '{32'h18202020, 24'h211515, 1'b1}, '{32'h18202020, 24'h21210f, 1'b0},
    '{32'h1f202020, 24'h211515, 1'b1}, '{32'h1f202020, 24'h151515, 1'b0},
    '{32'h14202020, 24'h211515, 1'b1}, '{32'h14202020, 24'h151515, 1'b0}};

  pcb_bank #(.TALLY_WIDTH(TW)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .pix_valid_i(pv), .pix_rgb_i(prgb),
    .pix_block_o(blk), .tri_walked_i(tw), .tri_culled_i(tc), .pix_walked_i(pw),
    .const_o(cst), .combine_other_rgb_o(corgb), .combine_other_alpha_o(coa),
    .other_rgb_sel_o(rsel), .other_alpha_sel_o(asel), .engine_stall_o(stall),
    .user_irq_o(irq));

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures = failures + 1;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Classic cycle: request held until ack is sampled, data taken there
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1);
    q = rdat;
    chk("ack_latency", 32'(n), 32'h2);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk($sformatf("read %h", a), q, e);
  endtask : rdchk

  task automatic settle;
    @(posedge clk_i);
    #1;
  endtask : settle

  task automatic pix(input logic [23:0] c, input logic e);
    @(posedge clk_i);
    pv <= 1'b1;
    prgb <= c;
    @(posedge clk_i);
    pv <= 1'b0;
    #1;
    chk("block", 32'(blk), 32'(e));
  endtask : pix

  task automatic ev(input logic t, input logic c, input logic p);
    @(posedge clk_i);
    tw <= t;
    tc <= c;
    pw <= p;
    @(posedge clk_i);
    tw <= 1'b0;
    tc <= 1'b0;
    pw <= 1'b0;
  endtask : ev

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(OFF_PIX, 32'h0);
    foreach (regs[i]) begin
      wr(regs[i].a, regs[i].d);
      rdchk(regs[i].a, regs[i].e);
    end
    chk("clear_depth", 32'(cst.clear_depth), 32'h1234);
    chk("lfb", {cst.lfb_alpha, 8'h00, cst.lfb_depth}, 32'hab001234);
    chk("bias_off", 32'(cst.bias_depth), 32'h0);
    chk("mask", cst.write_mask, 32'ha5a55a5a);
    chk("local", {cst.local_alpha, cst.local_rgb}, 32'h12345678);
    chk("other", {cst.other_alpha, cst.other_rgb}, 32'h89abcdef);
    chk("clear_rgb", 32'(cst.clear_rgb), 32'habcdef);
    chk("haze", 32'(cst.haze_rgb), 32'hffffff);
    chk("combine_off", {coa, corgb}, 32'h0);
    $display("test registers done");
    wr(OFF_FBMODE, 32'h00010002);
    wr(OFF_CPATH, 32'h0000000a);
    settle;
    chk("bias_on", 32'(cst.bias_depth), 32'h1234);
    chk("combine", {coa, corgb}, 32'h89abcdef);
    chk("path_sel", 32'({rsel, asel}), 32'h3);
    wr(OFF_KEY, 32'h00101010);
    foreach (chr[i]) begin
      wr(OFF_RANGE, chr[i].rng);
      pix(chr[i].px, chr[i].b);
    end
    $display("test table done");
    wr(OFF_FBMODE, 32'h0);
    wr(OFF_RANGE, 32'h0);
    pix(24'h101010, 1'b0);
    $display("test chroma off done");
    // Dropped while the enable bit is clear
    wr(OFF_SWIRQ, 32'h00000003);
    settle;
    chk("irq_drop", 32'({stall, irq}), 32'h0);
    rdchk(OFF_IRQCTL, 32'h0);
    wr(OFF_IRQCTL, 32'h00000020);
    wr(OFF_SWIRQ, 32'h00000169);
    settle;
    chk("irq_nostall", 32'({stall, irq}), 32'h1);
    wr(OFF_SWIRQ, 32'h0000030f);
    settle;
    chk("irq_stall", 32'({stall, irq}), 32'h3);
    rdchk(OFF_IRQCTL, 32'h000c3820);
    rdchk(OFF_SWIRQ, 32'h0);
    wr(OFF_IRQCTL, 32'h00000020);
    settle;
    chk("irq_clear", 32'({stall, irq}), 32'h0);
    $display("test irq done");
    repeat (18) ev(1'b0, 1'b0, 1'b1);
    ev(1'b1, 1'b0, 1'b0);
    ev(1'b1, 1'b1, 1'b0);
    ev(1'b1, 1'b0, 1'b0);
    ev(1'b1, 1'b0, 1'b0);
    rdchk(OFF_PIX, 32'(18 % (1 << TW)));
    rdchk(OFF_TRI, 32'h3);
    wr(OFF_TRI, 32'hffffffff);
    wr(OFF_FLUSH, 32'h1);
    rdchk(OFF_PIX, 32'h0);
    rdchk(OFF_TRI, 32'h3);
    wr(OFF_FLUSH, 32'h2);
    rdchk(OFF_TRI, 32'h0);
    $display("test tallies done");
    // Reset in mid-run clears registers and tallies again
    ev(1'b1, 1'b0, 1'b1);
    wr(OFF_SWIRQ, 32'h00000003);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(OFF_OTHER, 32'h0);
    rdchk(OFF_PIX, 32'h0);
    rdchk(OFF_TRI, 32'h0);
    chk("irq_reset", 32'({stall, irq}), 32'h0);
    $display("test reset done");
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
